// *** src/mcsr_axil.sv ***
`timescale 1ns/1ps
`include "mcsr_cfg.svh"
module mcsr_axil (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [`MCSR_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [`MCSR_ADDR_W-1:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output mcsr_pkg::mcsr_wreq_t wr_req,
	output mcsr_pkg::mcsr_rreq_t rd_req,
	input wire logic [31:0] rd_data
);
	logic aw_held_r, w_held_r, ar_held_r;
	logic [`MCSR_ADDR_W-1:0] awaddr_r, araddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic wr_issue, rd_issue, aw_nxt, w_nxt, ar_nxt, b_nxt, r_nxt;
	// ==========
	// one access at a time, write before read
	assign wr_issue = aw_held_r & w_held_r & ~s_axi_bvalid & ~s_axi_rvalid;
	assign rd_issue = ar_held_r & ~s_axi_rvalid & ~s_axi_bvalid & ~wr_issue;
	assign aw_nxt = (aw_held_r | (s_axi_awvalid & s_axi_awready)) & ~wr_issue;
	assign w_nxt = (w_held_r | (s_axi_wvalid & s_axi_wready)) & ~wr_issue;
	assign ar_nxt = (ar_held_r | (s_axi_arvalid & s_axi_arready)) & ~rd_issue;
	assign b_nxt = wr_issue | (s_axi_bvalid & ~s_axi_bready);
	assign r_nxt = rd_issue | (s_axi_rvalid & ~s_axi_rready);
	assign wr_req = {wr_issue, awaddr_r, wdata_r, wstrb_r};
	assign rd_req = {rd_issue, araddr_r};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			ar_held_r <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_arready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_rvalid <= 1'b0;
		end else begin
			aw_held_r <= aw_nxt;
			w_held_r <= w_nxt;
			ar_held_r <= ar_nxt;
			s_axi_awready <= ~aw_nxt & ~b_nxt;
			s_axi_wready <= ~w_nxt & ~b_nxt;
			s_axi_arready <= ~ar_nxt & ~r_nxt;
			s_axi_bvalid <= b_nxt;
			s_axi_rvalid <= r_nxt;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awaddr_r <= '0;
			araddr_r <= '0;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_bresp <= `MCSR_RESP_OKAY;
			s_axi_rresp <= `MCSR_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) awaddr_r <= s_axi_awaddr;
			if (s_axi_arvalid && s_axi_arready) araddr_r <= s_axi_araddr;
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (rd_issue) s_axi_rdata <= rd_data;
			s_axi_bresp <= `MCSR_RESP_OKAY;
			s_axi_rresp <= `MCSR_RESP_OKAY;
		end
	end
	// ==========
	// checks
	a_single_access: assert property (@(posedge aclk) disable iff (!aresetn)
		!(s_axi_bvalid && s_axi_rvalid)) else $error("write and read answered together");
	a_write_answered: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_issue |=> s_axi_bvalid && s_axi_bresp == 2'h0) else $error("write not answered");
	a_read_answered: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid)
		else $error("read not answered in time");
	c_both_pending: cover property (@(posedge aclk) disable iff (!aresetn) aw_held_r && ar_held_r);
endmodule : mcsr_axil

// *** src/mcsr_cfg.svh ***
`ifndef MCSR_CFG_SVH
`define MCSR_CFG_SVH
// ==========
// bus
`define MCSR_ADDR_W 20
`define MCSR_STRB_FULL 4'hf
`define MCSR_RESP_OKAY 2'h0
// ==========
// offsets
`define MCSR_OFS_CTRL 20'h00000
`define MCSR_OFS_STATUS 20'h00008
`define MCSR_OFS_PIN_SAMPLED_OPTIONS 20'h0000c
`define MCSR_OFS_EXT_CTRL 20'h00018
`define MCSR_OFS_PHY_MGMT 20'h00020
`define MCSR_OFS_NVM_FOUR 20'h00024
`define MCSR_OFS_NVM_ONE 20'h00028
`define MCSR_OFS_FUT_EXT 20'h0002c
`define MCSR_OFS_NVM_TWO 20'h00030
`define MCSR_OFS_LINK_CS 20'h00034
`define MCSR_OFS_BUS_DEV 20'h00038
`define MCSR_OFS_STA_LO 20'h00040
`define MCSR_OFS_STA_HI 20'h00044
`define MCSR_OFS_ETYPE 20'h00048
`define MCSR_OFS_EVT_CNT 20'h0004c
`define MCSR_OFS_OCT_LO 20'h00050
`define MCSR_OFS_OCT_HI 20'h00054
`define MCSR_OFS_CAUSE_W1C 20'h00058
`define MCSR_OFS_CAUSE_RC 20'h0005c
`define MCSR_OFS_CAUSE_SET 20'h00060
`define MCSR_OFS_LAT_TOL 20'h000f8
`define MCSR_OFS_LPI_CTL 20'h000fc
`define MCSR_OFS_FC_TX_TMR 20'h00170
`define MCSR_OFS_EXT_CFG 20'h00f00
`define MCSR_OFS_FC_REFRESH 20'h05f40
// ==========
// fields and resets
`define MCSR_CTRL_SEND 0
`define MCSR_CTRL_MIRROR 1
`define MCSR_CTRL_WMASK 32'h00ff_ffff
`define MCSR_EXT_RC_EN 0
`define MCSR_EXT_WMASK 32'h0000_ffff
`define MCSR_HALF_WMASK 32'h0000_ffff
`define MCSR_FULL_WMASK 32'hffff_ffff
`define MCSR_RST_REG 32'h0000_0000
`define MCSR_CAUSE_W 8
`define MCSR_SER_LAST 6'h3f
`endif

// *** src/mcsr_pkg.sv ***
`include "mcsr_cfg.svh"
package mcsr_pkg;
	typedef struct packed {
		logic valid;
		logic [`MCSR_ADDR_W-1:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} mcsr_wreq_t;
	typedef struct packed {
		logic valid;
		logic [`MCSR_ADDR_W-1:0] addr;
	} mcsr_rreq_t;
	typedef enum logic [0:0] {
		MCSR_SER_IDLE,
		MCSR_SER_SHIFT
	} mcsr_ser_state_t;
endpackage : mcsr_pkg

// *** src/mcsr_regs.sv ***
`timescale 1ns/1ps
`include "mcsr_cfg.svh"
module mcsr_regs #(
	parameter int OCT_INC_W = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [`MCSR_ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [`MCSR_ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	input wire logic [31:0] pin_sampled_options_pins,
	input wire logic [31:0] bus_dev_num,
	input wire logic nvm_load_valid,
	input wire logic [1:0] nvm_load_sel,
	input wire logic [31:0] nvm_load_data,
	input wire logic nvm_load_done,
	input wire logic an_done,
	input wire logic [31:0] an_result,
	input wire logic fw_wr_valid,
	input wire logic [31:0] fw_wr_data,
	input wire logic rx_event,
	input wire logic rx_octet_valid,
	input wire logic [OCT_INC_W-1:0] rx_octets,
	input wire logic [`MCSR_CAUSE_W-1:0] cause_events,
	output logic wire_bit,
	output logic wire_valid,
	output logic [31:0] ctrl_out,
	output logic [31:0] ext_ctrl_out
);
	localparam int AW = `MCSR_ADDR_W;
	localparam int CW = `MCSR_CAUSE_W;
	localparam int NPLAIN = 6;
	localparam int NNVM = 3;
	localparam logic [AW-1:0] PLAIN_OFS [NPLAIN] = '{`MCSR_OFS_PHY_MGMT, `MCSR_OFS_FUT_EXT,
		`MCSR_OFS_LAT_TOL, `MCSR_OFS_LPI_CTL, `MCSR_OFS_FC_TX_TMR, `MCSR_OFS_EXT_CFG};
	localparam logic [AW-1:0] NVM_OFS [NNVM] = '{`MCSR_OFS_NVM_ONE, `MCSR_OFS_NVM_TWO,
		`MCSR_OFS_NVM_FOUR};

	if (OCT_INC_W < 1 || OCT_INC_W > 32) begin : g_chk_inc
		$error("OCT_INC_W must lie in 1..32");
	end

	mcsr_pkg::mcsr_wreq_t wr;
	mcsr_pkg::mcsr_rreq_t rd;
	logic [31:0] rd_mux;
	logic [31:0] link_cs_r, refresh_thr_r, sta_lo_r, sta_hi_r, etype_r;
	logic [31:0] plain_r [NPLAIN];
	logic [31:0] nvm_r [NNVM];
	logic [31:0] evt_cnt_r, pin_sampled_options_r;
	logic [63:0] oct_r;
	logic [CW-1:0] w1c_r, rcwc_r;
	logic pin_sampled_options_taken_r, nvm_done_r, an_done_r;
	logic [7:0] drop_cnt_r;
	mcsr_pkg::mcsr_ser_state_t ser_r;
	logic [63:0] shift_r;
	logic [5:0] bit_cnt_r;

	// ==========
	// access decode helpers
	function automatic logic full_wr(mcsr_pkg::mcsr_wreq_t r, logic [AW-1:0] a);
		return r.valid && r.addr == a && r.strb == `MCSR_STRB_FULL;
	endfunction : full_wr

	function automatic logic rd_hit(mcsr_pkg::mcsr_rreq_t r, logic [AW-1:0] a);
		return r.valid && r.addr == a;
	endfunction : rd_hit

	function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] d,
		logic [31:0] m);
		return (old & ~m) | (d & m);
	endfunction : merge

	// ==========
	// bus slave
	mcsr_axil u_axil (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.wr_req(wr),
		.rd_req(rd),
		.rd_data(rd_mux)
	);

	// ==========
	// control registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_out <= `MCSR_RST_REG;
		end else if (full_wr(wr, `MCSR_OFS_CTRL)) begin
			ctrl_out <= merge(ctrl_out, wr.data, `MCSR_CTRL_WMASK);
		end else begin
			ctrl_out[`MCSR_CTRL_SEND] <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_ctrl_out <= `MCSR_RST_REG;
		end else if (full_wr(wr, `MCSR_OFS_EXT_CTRL)) begin
			ext_ctrl_out <= merge(ext_ctrl_out, wr.data, `MCSR_EXT_WMASK);
		end
	end

	for (genvar i = 0; i < NPLAIN; i++) begin : g_plain
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				plain_r[i] <= `MCSR_RST_REG;
			end else if (full_wr(wr, PLAIN_OFS[i])) begin
				plain_r[i] <= wr.data;
			end
		end
	end

	// memory load replaces the default, host may write afterwards
	for (genvar i = 0; i < NNVM; i++) begin : g_nvm
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				nvm_r[i] <= `MCSR_RST_REG;
			end else if (nvm_load_valid && nvm_load_sel == 2'(i)) begin
				nvm_r[i] <= nvm_load_data;
			end else if (full_wr(wr, NVM_OFS[i])) begin
				nvm_r[i] <= wr.data;
			end
		end
	end

	// negotiation result overrides the link control word
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			link_cs_r <= `MCSR_RST_REG;
		end else if (an_done) begin
			link_cs_r <= an_result;
		end else if (full_wr(wr, `MCSR_OFS_LINK_CS)) begin
			link_cs_r <= wr.data;
		end
	end

	// host writes are ignored here
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			refresh_thr_r <= `MCSR_RST_REG;
		end else if (fw_wr_valid) begin
			refresh_thr_r <= fw_wr_data;
		end
	end

	// ==========
	// station address and ethertype
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sta_lo_r <= `MCSR_RST_REG;
			sta_hi_r <= `MCSR_RST_REG;
			etype_r <= `MCSR_RST_REG;
		end else begin
			if (full_wr(wr, `MCSR_OFS_STA_LO)) sta_lo_r <= wr.data;
			if (full_wr(wr, `MCSR_OFS_STA_HI)) begin
				sta_hi_r <= merge(sta_hi_r, wr.data, `MCSR_HALF_WMASK);
			end
			if (full_wr(wr, `MCSR_OFS_ETYPE)) begin
				etype_r <= merge(etype_r, wr.data, `MCSR_HALF_WMASK);
			end
		end
	end

	// ==========
	// status sources
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_sampled_options_r <= `MCSR_RST_REG;
			pin_sampled_options_taken_r <= 1'b0;
		end else if (!pin_sampled_options_taken_r) begin
			pin_sampled_options_r <= pin_sampled_options_pins;
			pin_sampled_options_taken_r <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			nvm_done_r <= 1'b0;
			an_done_r <= 1'b0;
		end else begin
			nvm_done_r <= nvm_done_r | nvm_load_done;
			an_done_r <= an_done_r | an_done;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			drop_cnt_r <= 8'h00;
		end else if (wr.valid && wr.strb != `MCSR_STRB_FULL) begin
			drop_cnt_r <= drop_cnt_r + 8'h01;
		end
	end

	// ==========
	// counters
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			evt_cnt_r <= `MCSR_RST_REG;
		end else if (rd_hit(rd, `MCSR_OFS_EVT_CNT)) begin
			evt_cnt_r <= {31'h0000_0000, rx_event};
		end else if (rx_event) begin
			evt_cnt_r <= evt_cnt_r + 32'h0000_0001;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			oct_r <= 64'h0;
		end else if (rx_octet_valid) begin
			oct_r <= oct_r + 64'(rx_octets);
		end
	end

	// ==========
	// cause registers, a new event wins over a clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w1c_r <= '0;
		end else begin
			w1c_r <= (w1c_r & ~(full_wr(wr, `MCSR_OFS_CAUSE_W1C) ? wr.data[CW-1:0] : '0))
				| cause_events;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rcwc_r <= '0;
		end else if (rd_hit(rd, `MCSR_OFS_CAUSE_RC) && ext_ctrl_out[`MCSR_EXT_RC_EN]) begin
			rcwc_r <= cause_events;
		end else begin
			rcwc_r <= (rcwc_r & ~(full_wr(wr, `MCSR_OFS_CAUSE_RC) ? wr.data[CW-1:0] : '0))
				| cause_events
				| (full_wr(wr, `MCSR_OFS_CAUSE_SET) ? wr.data[CW-1:0] : '0);
		end
	end

	// ==========
	// wire serializer: address bytes in order, then ethertype
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ser_r <= mcsr_pkg::MCSR_SER_IDLE;
			shift_r <= 64'h0;
			bit_cnt_r <= 6'h00;
			wire_bit <= 1'b0;
			wire_valid <= 1'b0;
		end else begin
			case (ser_r)
				mcsr_pkg::MCSR_SER_IDLE: begin
					wire_valid <= 1'b0;
					wire_bit <= 1'b0;
					if (ctrl_out[`MCSR_CTRL_SEND]) begin
						shift_r <= {etype_r[7:0], etype_r[15:8], sta_hi_r[15:0],
							sta_lo_r};
						bit_cnt_r <= 6'h00;
						ser_r <= mcsr_pkg::MCSR_SER_SHIFT;
					end
				end
				mcsr_pkg::MCSR_SER_SHIFT: begin
					wire_bit <= shift_r[0];
					wire_valid <= 1'b1;
					shift_r <= {1'b0, shift_r[63:1]};
					bit_cnt_r <= bit_cnt_r + 6'h01;
					if (bit_cnt_r == `MCSR_SER_LAST) ser_r <= mcsr_pkg::MCSR_SER_IDLE;
				end
				default: begin
					ser_r <= mcsr_pkg::MCSR_SER_IDLE;
				end
			endcase
		end
	end

	// ==========
	// read mux, unmapped and write-only read zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		for (int i = 0; i < NPLAIN; i++) begin
			if (rd.addr == PLAIN_OFS[i]) rd_mux = plain_r[i];
		end
		for (int i = 0; i < NNVM; i++) begin
			if (rd.addr == NVM_OFS[i]) rd_mux = nvm_r[i];
		end
		case (rd.addr)
			`MCSR_OFS_CTRL: rd_mux = ctrl_out;
			`MCSR_OFS_STATUS: rd_mux = {16'h0000, drop_cnt_r, 4'h0,
				ser_r != mcsr_pkg::MCSR_SER_IDLE, ctrl_out[`MCSR_CTRL_MIRROR],
				an_done_r, nvm_done_r};
			`MCSR_OFS_PIN_SAMPLED_OPTIONS: rd_mux = pin_sampled_options_r;
			`MCSR_OFS_EXT_CTRL: rd_mux = ext_ctrl_out;
			`MCSR_OFS_LINK_CS: rd_mux = link_cs_r;
			`MCSR_OFS_BUS_DEV: rd_mux = bus_dev_num;
			`MCSR_OFS_FC_REFRESH: rd_mux = refresh_thr_r;
			`MCSR_OFS_STA_LO: rd_mux = sta_lo_r;
			`MCSR_OFS_STA_HI: rd_mux = sta_hi_r;
			`MCSR_OFS_ETYPE: rd_mux = etype_r;
			`MCSR_OFS_EVT_CNT: rd_mux = evt_cnt_r;
			`MCSR_OFS_OCT_LO: rd_mux = oct_r[31:0];
			`MCSR_OFS_OCT_HI: rd_mux = oct_r[63:32];
			`MCSR_OFS_CAUSE_W1C: rd_mux = 32'(w1c_r);
			`MCSR_OFS_CAUSE_RC: rd_mux = 32'(rcwc_r);
			default: begin
			end
		endcase
	end

	// ==========
	// checks
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_partial_dropped: assert property (wr.valid && wr.addr == `MCSR_OFS_EXT_CTRL
		&& wr.strb != 4'hf |=> $stable(ext_ctrl_out)) else $error("partial write took effect");
	a_self_clear: assert property (ctrl_out[`MCSR_CTRL_SEND] |=> !ctrl_out[`MCSR_CTRL_SEND])
		else $error("self-clearing bit stuck");
	a_cor_reset: assert property (rd_hit(rd, `MCSR_OFS_EVT_CNT) |=>
		evt_cnt_r == {31'h0, $past(rx_event)} && s_axi_rdata == $past(evt_cnt_r))
		else $error("clear-on-read wrong");
	a_w1c_clear: assert property (full_wr(wr, `MCSR_OFS_CAUSE_W1C) |=>
		(w1c_r & $past(wr.data[CW-1:0]) & ~$past(cause_events)) == '0
		&& (w1c_r & ~$past(wr.data[CW-1:0])) == ($past(w1c_r | cause_events)
		& ~$past(wr.data[CW-1:0]))) else $error("write-one-to-clear wrong");
	a_rc_read_clear: assert property (rd_hit(rd, `MCSR_OFS_CAUSE_RC)
		&& ext_ctrl_out[0] |=> rcwc_r == $past(cause_events)) else $error("read clear failed");
	a_wo_reads_zero: assert property (rd_hit(rd, `MCSR_OFS_CAUSE_SET) |=> s_axi_rdata == 32'h0)
		else $error("write-only read not zero");
	a_an_override: assert property (an_done |=> link_cs_r == $past(an_result))
		else $error("negotiation result not loaded");
	a_nvm_load: assert property (nvm_load_valid && nvm_load_sel == 2'h1 |=>
		nvm_r[1] == $past(nvm_load_data)) else $error("memory load not taken");
	a_fw_only: assert property (!fw_wr_valid |=> $stable(refresh_thr_r))
		else $error("host changed firmware register");
	a_ser_first: assert property ($rose(wire_valid) |-> wire_bit == $past(sta_lo_r[0], 2))
		else $error("first wire bit wrong");
	a_ser_length: assert property ($rose(wire_valid) |-> ##63 wire_valid ##1 !wire_valid)
		else $error("wire frame length wrong");

	c_partial_write: cover property (wr.valid && wr.strb != 4'hf);
	c_cor_with_event: cover property (rd_hit(rd, `MCSR_OFS_EVT_CNT) && rx_event);
	c_wire_frame: cover property ($fell(wire_valid));
	c_rc_clear: cover property (rd_hit(rd, `MCSR_OFS_CAUSE_RC) && ext_ctrl_out[0] && rcwc_r != '0);
endmodule : mcsr_regs

// *** tb/mcsr_regs_tb_top.sv ***
`timescale 1ns/1ps
module mcsr_regs_tb_top;
	// ==========
	// signals
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, wire_bit, wire_valid;
	logic [19:0] awaddr = 20'h0, araddr = 20'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, ctrl_out, ext_ctrl_out;
	logic [31:0] pin_sampled_options_pins = 32'h0, bus_dev_num = 32'h0, nvm_load_data = 32'h0;
	logic [31:0] an_result = 32'h0, fw_wr_data = 32'h0, rx_octets = 32'h0;
	logic nvm_load_valid = 1'b0, nvm_load_done = 1'b0, an_done = 1'b0, fw_wr_valid = 1'b0;
	logic rx_event = 1'b0, rx_octet_valid = 1'b0;
	logic [1:0] nvm_load_sel = 2'h0;
	logic [7:0] cause_events = 8'h0;
	int seed = 45119;
	int miscompares = 0;
	int n_checks = 0;
	logic [31:0] v, strap0, sta_lo, sta_hi, et;
	logic [63:0] fr;
	logic [31:0] nv [3];
	logic [7:0] drops;
	logic [3:0] s;
	logic [19:0] rw_ofs [6] = '{20'h00020, 20'h0002c, 20'h000f8, 20'h000fc, 20'h00170, 20'h00f00};
	logic [19:0] nvm_ofs [3] = '{20'h00028, 20'h00030, 20'h00024};
	always #20 aclk = ~aclk;
	mcsr_regs #(.OCT_INC_W(32)) uut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .pin_sampled_options_pins(pin_sampled_options_pins),
		.bus_dev_num(bus_dev_num), .nvm_load_valid(nvm_load_valid),
		.nvm_load_sel(nvm_load_sel), .nvm_load_data(nvm_load_data),
		.nvm_load_done(nvm_load_done), .an_done(an_done), .an_result(an_result),
		.fw_wr_valid(fw_wr_valid), .fw_wr_data(fw_wr_data), .rx_event(rx_event),
		.rx_octet_valid(rx_octet_valid), .rx_octets(rx_octets),
		.cause_events(cause_events), .wire_bit(wire_bit), .wire_valid(wire_valid),
		.ctrl_out(ctrl_out), .ext_ctrl_out(ext_ctrl_out)
	);
	// ==========
	// checks and verdict
	task automatic complete_run();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run
	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: word %h expected %h", $time, got, exp);
		end
	endtask : check_word
	task automatic check_bit(input logic got, input logic exp, input int idx);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: bit %0d is %b expected %b", $time, idx, got, exp);
		end
	endtask : check_bit
	// wire byte k at bits 8k+7..8k, each byte least significant bit first
	function automatic logic [63:0] exp_frame(input logic [31:0] lo, input logic [31:0] hi,
		input logic [31:0] ety);
		return {ety[7:0], ety[15:8], hi[15:8], hi[7:0], lo[31:24], lo[23:16], lo[15:8],
			lo[7:0]};
	endfunction : exp_frame
	// ==========
	// bus master
	task automatic axi_wr(input logic [19:0] a, input logic [31:0] d, input logic [3:0] st);
		logic aw_ok, w_ok;
		@(posedge aclk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		wstrb <= st;
		bready <= 1'b1;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && awready === 1'b1) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready === 1'b1) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do begin
			@(posedge aclk);
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		check_word({30'h0, bresp}, 32'h0);
	endtask : axi_wr
	task automatic axi_rd(input logic [19:0] a, output logic [31:0] d);
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
		end while (arready !== 1'b1);
		arvalid <= 1'b0;
		do begin
			@(posedge aclk);
		end while (rvalid !== 1'b1);
		d = rdata;
		rready <= 1'b0;
		check_word({30'h0, rresp}, 32'h0);
	endtask : axi_rd
	task automatic rd_chk(input logic [19:0] a, input logic [31:0] exp);
		logic [31:0] d;
		axi_rd(a, d);
		check_word(d, exp);
	endtask : rd_chk
	// ==========
	// watchdog
	initial begin
		#2000000;
		miscompares++;
		$display("Error at %0t: run did not finish", $time);
		complete_run();
	end
	// ==========
	// scenarios
	initial begin
		strap0 = $random(seed);
		pin_sampled_options_pins = strap0;
		drops = 8'h0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		pin_sampled_options_pins <= ~strap0;
		v = $random(seed);
		bus_dev_num <= v;
		rd_chk(20'h0000c, strap0);
		rd_chk(20'h00038, v);
		rd_chk(20'h00000, 32'h0);
		for (int i = 0; i < 6; i++) begin
			rd_chk(rw_ofs[i], 32'h0);
			v = $random(seed);
			axi_wr(rw_ofs[i], v, 4'hf);
			rd_chk(rw_ofs[i], v);
			s = 4'($random(seed));
			if (s == 4'hf) s = 4'h7;
			axi_wr(rw_ofs[i], ~v, s);
			drops++;
			rd_chk(rw_ofs[i], v);
		end
		v = $random(seed);
		axi_wr(20'h00000, (v & 32'h00ff_fffc) | 32'h2, 4'hf);
		rd_chk(20'h00000, (v & 32'h00ff_fffc) | 32'h2);
		check_word(ctrl_out, (v & 32'h00ff_fffc) | 32'h2);
		axi_wr(20'h00018, 32'hffff_fffe, 4'hf);
		rd_chk(20'h00018, 32'h0000_fffe);
		check_word(ext_ctrl_out, 32'h0000_fffe);
		axi_wr(20'h00018, 32'h0000_0001, 4'h3);
		drops++;
		rd_chk(20'h00018, 32'h0000_fffe);
		check_word(ext_ctrl_out, 32'h0000_fffe);
		axi_wr(20'h00004, 32'hffff_ffff, 4'hf);
		rd_chk(20'h00004, 32'h0);
		axi_wr(20'h00021, 32'h1234_5678, 4'hf);
		rd_chk(20'h00021, 32'h0);
		sta_lo = $random(seed);
		sta_hi = $random(seed);
		et = $random(seed);
		axi_wr(20'h00040, sta_lo, 4'hf);
		axi_wr(20'h00044, sta_hi, 4'hf);
		axi_wr(20'h00048, et, 4'hf);
		rd_chk(20'h00040, sta_lo);
		rd_chk(20'h00044, {16'h0, sta_hi[15:0]});
		rd_chk(20'h00048, {16'h0, et[15:0]});
		fr = exp_frame(sta_lo, sta_hi, et);
		axi_wr(20'h00000, 32'h3, 4'hf);
		for (int t = 0; t < 10 && wire_valid !== 1'b1; t++) @(posedge aclk);
		check_bit(wire_valid, 1'b1, -1);
		for (int i = 0; i < 64; i++) begin
			check_bit(wire_bit, fr[i], i);
			@(posedge aclk);
		end
		check_bit(wire_valid, 1'b0, 64);
		rd_chk(20'h00000, 32'h2);
		for (int i = 0; i < 4; i++) begin
			v = $random(seed);
			if (i < 3) nv[i] = v;
			@(posedge aclk);
			nvm_load_valid <= 1'b1;
			nvm_load_sel <= i[1:0];
			nvm_load_data <= v;
			@(posedge aclk);
			nvm_load_valid <= 1'b0;
		end
		for (int i = 0; i < 3; i++) rd_chk(nvm_ofs[i], nv[i]);
		v = $random(seed);
		@(posedge aclk);
		nvm_load_done <= 1'b1;
		an_done <= 1'b1;
		an_result <= v;
		@(posedge aclk);
		nvm_load_done <= 1'b0;
		an_done <= 1'b0;
		rd_chk(20'h00034, v);
		rd_chk(20'h00008, {16'h0, drops, 8'h07});
		axi_wr(20'h05f40, 32'hdead_0001, 4'hf);
		rd_chk(20'h05f40, 32'h0);
		v = $random(seed);
		@(posedge aclk);
		fw_wr_valid <= 1'b1;
		fw_wr_data <= v;
		@(posedge aclk);
		fw_wr_valid <= 1'b0;
		rd_chk(20'h05f40, v);
		s = $random(seed);
		for (int i = 0; i <= s; i++) begin
			@(posedge aclk);
			rx_event <= 1'b1;
			@(posedge aclk);
			rx_event <= 1'b0;
		end
		rd_chk(20'h0004c, {28'h0, s} + 32'h1);
		rd_chk(20'h0004c, 32'h0);
		for (int i = 0; i < 3; i++) begin
			@(posedge aclk);
			rx_octet_valid <= 1'b1;
			rx_octets <= 32'hffff_fff0;
			@(posedge aclk);
			rx_octet_valid <= 1'b0;
		end
		rd_chk(20'h00050, 32'hffff_ffd0);
		rd_chk(20'h00054, 32'h2);
		@(posedge aclk);
		cause_events <= 8'ha5;
		@(posedge aclk);
		cause_events <= 8'h00;
		rd_chk(20'h00058, 32'ha5);
		axi_wr(20'h00058, 32'h0f, 4'hf);
		rd_chk(20'h00058, 32'ha0);
		rd_chk(20'h0005c, 32'ha5);
		axi_wr(20'h0005c, 32'h01, 4'hf);
		rd_chk(20'h0005c, 32'ha4);
		axi_wr(20'h00018, 32'h1, 4'hf);
		rd_chk(20'h0005c, 32'ha4);
		rd_chk(20'h0005c, 32'h0);
		axi_wr(20'h00060, 32'h11, 4'hf);
		rd_chk(20'h00060, 32'h0);
		rd_chk(20'h0005c, 32'h11);
		complete_run();
	end
endmodule : mcsr_regs_tb_top
